// >>> hdl/pcg_regs.vh
/*
 * register map, field positions, reset values and event codes of the
 * peripheral clock gating block.
 * assumes a 32-bit apb slave with byte addresses, one word per register.
 */
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

`define PCG_ADDR_W 12
`define PCG_OFF_RUN_CFG 12'h060
`define PCG_OFF_GATE_ZERO 12'h100
`define PCG_OFF_GATE_ONE 12'h104
`define PCG_OFF_SLEEP_ONE 12'h114
`define PCG_OFF_DEEP_ONE 12'h124
`define PCG_OFF_IRQ_STATUS 12'h200
`define PCG_OFF_IRQ_CLEAR 12'h204
`define PCG_OFF_IRQ_ENABLE 12'h208

`define PCG_RESET_WORD 32'h00000000

// writable bits of each gating word; all others are reserved and read zero
`define PCG_GATE_ONE_MASK 32'h570f53f7
`define PCG_GATE_ZERO_MASK 32'h00000048
`define PCG_BIT_HIB 6
`define PCG_BIT_WATCHDOG_ZERO_ENABLE 3
`define PCG_BIT_EXT_PERIPH_IF_ENABLE 30
`define PCG_BIT_AUDIO_SERIAL_ZERO_ENABLE 28
`define PCG_BIT_AUTO_GATE 27

// module index space: 0..31 gate-one bits, 32..38 gate-zero bits 0..6
`define PCG_NUM_MOD 39
`define PCG_ID_W 6

// interrupt status bits
`define PCG_EVT_RD_FAULT 0
`define PCG_EVT_WR_FAULT 1
`define PCG_EVT_W 2

// power modes
`define PCG_MODE_RUN 2'h0
`define PCG_MODE_SLEEP 2'h1
`define PCG_MODE_DEEP 2'h2

`endif

// >>> hdl/pcg_clk_gate.v
/*
 * glitch-free clock gate cell for one peripheral clock.
 * assumes en is synchronous to clk; it is re-timed on the low phase.
 */
`timescale 1ns/1ps
module pcg_clk_gate (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire en,
    // gated clock
    output wire gclk
);
    reg en_low_reg;

    // enable only changes while clk is low, so no pulse is ever cut short
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_low_reg <= 1'b0;
        end else begin
            en_low_reg <= en;
        end
    end

    assign gclk = clk & en_low_reg; // RL18
endmodule // pcg_clk_gate

// >>> hdl/pcg_clock_gating.v
/*
 * peripheral clock gating: run, sleep and deep-sleep gating words, an apb
 * register slave, one gated clock per peripheral and a bus fault check.
 * assumes the processor reports each peripheral access on periph_access
 * with the peripheral index, and that sleep inputs are synchronous to pclk.
 */
// What this block does
// RL1 - enable bit clocks module, zero disables it
// RL2 - access to unclocked module gives bus fault
// RL3 - gating word resets to all zero
// RL4 - software enables modules before using them
// RL5 - run, sleep, deep-sleep gating words provided; gate zero has only a run word here
// RL6 - sleep words apply only with auto gating
// RL7 - run gating word one at 0x104
// RL8 - gate zero bit 6 enables hibernation
// RL9 - gate zero bit 3 enables watchdog zero
// RL10 - bit 30 enables external peripheral interface
// RL11 - bit 28 enables audio serial zero
// RL12 - reserved bits read only, read zero
// RL13 - software preserves reserved bits on update
// RL14 - unused enable bits harm nothing
// RL15 - bits 26..24 enable comparators two..zero
// RL16 - bits 19..16 enable counters three..zero
// RL17 - bits 14, 12 enable two-wire one, zero
// RL18 - glitch-free gate cell per module
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_clock_gating (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PCG_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // power mode requests from the core
    input wire sleep_req,
    input wire deep_sleep_req,
    // peripheral access check
    input wire periph_access,
    input wire periph_write,
    input wire [`PCG_ID_W-1:0] periph_id,
    output reg periph_fault,
    // gated clocks and enables
    output wire [`PCG_NUM_MOD-1:0] periph_gclk,
    output reg [`PCG_NUM_MOD-1:0] periph_enable,
    // interrupt
    output reg irq
);
    reg [31:0] run_clock_config_reg;
    reg [31:0] run_clock_gate_zero_reg;
    reg [31:0] run_clock_gate_one_reg;
    reg [31:0] sleep_clock_gate_one_reg;
    reg [31:0] deep_sleep_clock_gate_one_reg;
    reg [`PCG_EVT_W-1:0] irq_status_reg;
    reg [`PCG_EVT_W-1:0] irq_enable_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [31:0] gate_sel_next;
    reg [`PCG_NUM_MOD-1:0] enable_next;
    reg [31:0] rdata_next;
    reg addr_ok_next;
    reg [`PCG_EVT_W-1:0] evt_set;
    reg [`PCG_EVT_W-1:0] evt_clr;

    wire setup_phase;
    wire wr_commit;
    wire auto_gating_select;

    assign setup_phase = psel & ~penable;
    assign wr_commit = psel & penable & pready & pwrite & ~pslverr;
    assign auto_gating_select = run_clock_config_reg[`PCG_BIT_AUTO_GATE];

    // power mode picks which gate-one word drives clocks 0..31
    always @* begin
        mode_next = `PCG_MODE_RUN;
        if (auto_gating_select) begin // RL6
            if (deep_sleep_req) begin
                mode_next = `PCG_MODE_DEEP;
            end else if (sleep_req) begin
                mode_next = `PCG_MODE_SLEEP;
            end
        end
    end

    always @* begin
        case (mode_reg)
            `PCG_MODE_SLEEP: gate_sel_next = sleep_clock_gate_one_reg; // RL5
            `PCG_MODE_DEEP: gate_sel_next = deep_sleep_clock_gate_one_reg; // RL5
            default: gate_sel_next = run_clock_gate_one_reg;
        endcase
        // gate-zero has no sleep copies here, so it follows run mode always
        enable_next = {run_clock_gate_zero_reg[6:0], gate_sel_next};
    end

    // read decode is done in the setup phase so prdata is a flop output
    always @* begin
        rdata_next = 32'h00000000;
        addr_ok_next = 1'b1;
        case (paddr)
            `PCG_OFF_RUN_CFG: rdata_next = run_clock_config_reg;
            `PCG_OFF_GATE_ZERO: rdata_next = run_clock_gate_zero_reg; // RL8 RL9
            `PCG_OFF_GATE_ONE: rdata_next = run_clock_gate_one_reg; // RL7
            `PCG_OFF_SLEEP_ONE: rdata_next = sleep_clock_gate_one_reg;
            `PCG_OFF_DEEP_ONE: rdata_next = deep_sleep_clock_gate_one_reg;
            `PCG_OFF_IRQ_STATUS: rdata_next = {30'h00000000, irq_status_reg};
            `PCG_OFF_IRQ_CLEAR: rdata_next = 32'h00000000;
            `PCG_OFF_IRQ_ENABLE: rdata_next = {30'h00000000, irq_enable_reg};
            default: addr_ok_next = 1'b0;
        endcase
    end

    // apb answer: one wait-free access phase after every setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `PCG_RESET_WORD;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= ~addr_ok_next;
                prdata <= pwrite ? 32'h00000000 : rdata_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // gating words; masks keep reserved bits at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_config_reg <= `PCG_RESET_WORD;
            run_clock_gate_zero_reg <= `PCG_RESET_WORD; // RL3
            run_clock_gate_one_reg <= `PCG_RESET_WORD; // RL3
            sleep_clock_gate_one_reg <= `PCG_RESET_WORD;
            deep_sleep_clock_gate_one_reg <= `PCG_RESET_WORD;
            irq_enable_reg <= 2'h0;
        end else if (wr_commit) begin
            case (paddr)
                `PCG_OFF_RUN_CFG: begin
                    run_clock_config_reg <= pwdata & (32'h1 << `PCG_BIT_AUTO_GATE);
                end
                `PCG_OFF_GATE_ZERO: begin
                    run_clock_gate_zero_reg <= pwdata & `PCG_GATE_ZERO_MASK; // RL8 RL9 RL12
                end
                `PCG_OFF_GATE_ONE: begin
                    // RL10 RL11 RL15 RL16 RL17
                    run_clock_gate_one_reg <= pwdata & `PCG_GATE_ONE_MASK; // RL12
                end
                `PCG_OFF_SLEEP_ONE: begin
                    sleep_clock_gate_one_reg <= pwdata & `PCG_GATE_ONE_MASK; // RL5
                end
                `PCG_OFF_DEEP_ONE: begin
                    deep_sleep_clock_gate_one_reg <= pwdata & `PCG_GATE_ONE_MASK; // RL5
                end
                `PCG_OFF_IRQ_ENABLE: begin
                    irq_enable_reg <= pwdata[`PCG_EVT_W-1:0];
                end
                default: begin
                    irq_enable_reg <= irq_enable_reg;
                end
            endcase
        end
    end

    // enables are re-timed once so every consumer sees the same edge;
    // bits of absent modules simply drive clocks nobody uses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `PCG_MODE_RUN;
            periph_enable <= {`PCG_NUM_MOD{1'b0}};
        end else begin
            mode_reg <= mode_next;
            periph_enable <= enable_next; // RL1 RL14
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PCG_NUM_MOD; gi = gi + 1) begin : g_gate
            pcg_clk_gate u_gate (
                .clk(pclk),
                .rst_n(presetn),
                .en(periph_enable[gi]),
                .gclk(periph_gclk[gi])
            ); // RL1 RL18
        end
    endgenerate

    // fault check against the enables the peripherals are actually getting
    wire id_in_range;
    wire target_on;
    assign id_in_range = (periph_id < `PCG_NUM_MOD);
    assign target_on = id_in_range & periph_enable[periph_id];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_fault <= 1'b0;
        end else begin
            periph_fault <= periph_access & ~target_on; // RL2
        end
    end

    // sticky events; a set in the same cycle as its clear wins
    always @* begin
        evt_set = 2'h0;
        evt_set[`PCG_EVT_RD_FAULT] = periph_access & ~target_on & ~periph_write; // RL2
        evt_set[`PCG_EVT_WR_FAULT] = periph_access & ~target_on & periph_write; // RL2
        evt_clr = 2'h0;
        if (wr_commit && paddr == `PCG_OFF_IRQ_CLEAR) begin
            evt_clr = pwdata[`PCG_EVT_W-1:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~evt_clr) | evt_set;
            irq <= |(((irq_status_reg & ~evt_clr) | evt_set) & irq_enable_reg);
        end
    end
endmodule // pcg_clock_gating

// >>> dv/pcg_clock_gating_properties.sv
/* port assertions for the clock gating block.
   assumes one pclk domain; bound to pcg_clock_gating below. */
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_props (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PCG_ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // peripheral side
    input wire periph_access,
    input wire [`PCG_ID_W-1:0] periph_id,
    input wire periph_fault,
    input wire [`PCG_NUM_MOD-1:0] periph_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an id past the table always counts as unclocked
    wire id_off = periph_id >= `PCG_NUM_MOD || !periph_enable[periph_id];
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(a);
        pready && !pwrite && paddr == a;
    endsequence
    AST_ANSWER: assert property (s_setup |=> pready && psel && penable)
        else $error("no answer after setup");
    AST_RSV_ONE: assert property (s_rd(`PCG_OFF_GATE_ONE) |->
        (prdata & ~`PCG_GATE_ONE_MASK) == 0) else $error("reserved bit set");
    AST_RSV_ZERO: assert property (s_rd(`PCG_OFF_GATE_ZERO) |->
        (prdata & ~`PCG_GATE_ZERO_MASK) == 0) else $error("reserved bit set");
    AST_FAULT: assert property (periph_access && id_off |=> periph_fault)
        else $error("missing fault");
    AST_NO_FAULT: assert property (periph_access && !id_off |=> !periph_fault)
        else $error("fault on clocked module");
    AST_FAULT_CAUSE: assert property (periph_fault |-> $past(periph_access))
        else $error("fault without access");
    AST_SPARE: assert property ((periph_enable[31:0] & ~`PCG_GATE_ONE_MASK) == 0
        && periph_enable[37:36] == 0 && periph_enable[34:32] == 0) else $error("spare on");
    AST_RESET: assert property ($rose(presetn) |-> periph_enable == 0)
        else $error("enable not clear after reset");
    AST_UNMAPPED: assert property (pready && paddr[11:10] == 2'b11 |->
        pslverr && prdata == 0) else $error("unmapped not refused");
endmodule // pcg_props
bind pcg_clock_gating pcg_props pcg_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_access(periph_access),
    .periph_id(periph_id), .periph_fault(periph_fault), .periph_enable(periph_enable));

// >>> dv/pcg_core_model.sv
/* core model: turns a bench command into one peripheral bus access.
   assumes req is a one-cycle pulse synchronous to pclk. */
`timescale 1ns/1ps
module pcg_core_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // command
    input wire req,
    input wire req_write,
    input wire [5:0] req_id,
    // system bus
    output reg periph_access,
    output reg periph_write,
    output reg [5:0] periph_id
);
    // idle bus scrambles id and direction so a stale value is never trusted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_access <= 1'b0;
            periph_write <= 1'b0;
            periph_id <= 6'h00;
        end else begin
            periph_access <= req;
            periph_write <= req ? req_write : ~periph_write;
            periph_id <= req ? req_id : ~periph_id;
        end
    end
endmodule // pcg_core_model

// >>> dv/pcg_clock_gating_tb_top.sv
/* self-checking bench for the clock gating block.
   assumes the core model issues peripheral accesses on pclk. */
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_clock_gating_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic sleep_req = 0, deep_sleep_req = 0, req = 0, req_write = 0;
    logic pready, pslverr, irq, periph_access, periph_write, periph_fault;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, v, s, d;
    logic [5:0] req_id = 0, periph_id;
    logic [38:0] periph_gclk, periph_enable;
    int failures = 0, comparisons = 0, cycles = 0;
    always #2 pclk = ~pclk;
    pcg_clock_gating pcg_clock_gating_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
        .deep_sleep_req(deep_sleep_req), .periph_access(periph_access),
        .periph_write(periph_write), .periph_id(periph_id), .periph_fault(periph_fault),
        .periph_gclk(periph_gclk), .periph_enable(periph_enable), .irq(irq));
    pcg_core_model pcg_core_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
        .req_write(req_write), .req_id(req_id), .periph_access(periph_access),
        .periph_write(periph_write), .periph_id(periph_id));
    task automatic check(input logic [38:0] seen, input logic [38:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        // pready is read at the rising edge, before the slave's flops move
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        check(q, exp);
    endtask
    task automatic ck(input logic [38:0] exp, input logic i);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check(i ? irq : periph_enable, exp);
        @(posedge pclk);
    endtask
    task automatic acc(input logic w, input logic [5:0] id, input logic f);
        req <= 1;
        req_write <= w;
        req_id <= id;
        @(posedge pclk);
        req <= 0;
        @(posedge pclk);
        @(negedge pclk);
        check(periph_fault, f);
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hf31e));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(`PCG_OFF_GATE_ONE, 0);
        rd(`PCG_OFF_GATE_ZERO, 0);
        apb(0, 12'hffc, 0);
        check(err, 1);
        acc(0, 28, 1);
        acc(1, 40, 1);
        rd(`PCG_OFF_IRQ_STATUS, 3);
        apb(1, `PCG_OFF_IRQ_ENABLE, 1);
        ck(1, 1);
        apb(1, `PCG_OFF_IRQ_ENABLE, 0);
        ck(0, 1);
        apb(1, `PCG_OFF_IRQ_ENABLE, 3);
        apb(1, `PCG_OFF_IRQ_CLEAR, 3);
        ck(0, 1);
        rd(`PCG_OFF_IRQ_STATUS, 0);
        apb(1, `PCG_OFF_GATE_ZERO, 32'hffffffff);
        rd(`PCG_OFF_GATE_ZERO, 32'h48);
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 32'hffffffff : $urandom;
            apb(1, `PCG_OFF_GATE_ONE, v);
            rd(`PCG_OFF_GATE_ONE, v & `PCG_GATE_ONE_MASK);
            ck({7'h48, v & `PCG_GATE_ONE_MASK}, 0);
        end
        apb(0, `PCG_OFF_GATE_ONE, 0);
        v = q | 32'h10000000;
        apb(1, `PCG_OFF_GATE_ONE, v);
        acc(1, 28, 0);
        acc(0, 38, 0);
        acc(1, 35, 0);
        @(posedge pclk);
        #1;
        check(periph_gclk[`PCG_BIT_AUDIO_SERIAL_ZERO_ENABLE], 1);
        @(posedge pclk);
        s = $urandom;
        d = $urandom;
        apb(1, `PCG_OFF_SLEEP_ONE, s);
        apb(1, `PCG_OFF_DEEP_ONE, d);
        apb(1, `PCG_OFF_RUN_CFG, 32'hffffffff);
        rd(`PCG_OFF_RUN_CFG, 32'h08000000);
        sleep_req <= 1;
        ck({7'h48, s & `PCG_GATE_ONE_MASK}, 0);
        deep_sleep_req <= 1;
        ck({7'h48, d & `PCG_GATE_ONE_MASK}, 0);
        apb(1, `PCG_OFF_RUN_CFG, 0);
        ck({7'h48, v & `PCG_GATE_ONE_MASK}, 0);
        conclude();
    end
endmodule // pcg_clock_gating_tb_top
